//--- rtl/tpa_pkg.sv
// tpa_pkg: register map, field layout, reset values and timing for the throttle
// profile and monitor converter control block; assumes a 200 MHz core clock.
package tpa_pkg;
  localparam int unsigned TPA_CLK_MHZ = 200;
  localparam int TPA_CNT_W = 28;

  // byte addresses
  localparam logic [7:0] TPA_ADDR_PROF_LO = 8'h38;
  localparam logic [7:0] TPA_ADDR_PROF_HI = 8'h39;
  localparam logic [7:0] TPA_ADDR_ADC_LO = 8'h3a;
  localparam logic [7:0] TPA_ADDR_ADC_HI = 8'h3b;

  localparam logic [15:0] TPA_PROF_RST = 16'h8120;
  localparam logic [15:0] TPA_ADC_RST = 16'h2000;

  // throttle_profile_config fields
  localparam int TPA_THR_LSB = 10;
  localparam int TPA_THR_W = 6;
  localparam int TPA_DEG_LSB = 8;
  localparam int TPA_PROF_EN_W = 7;
  localparam int TPA_EN_COMP = 6;
  localparam int TPA_EN_CRIT = 5;
  localparam int TPA_EN_NOM = 4;
  localparam int TPA_EN_DISCH = 3;
  localparam int TPA_EN_SYSV = 2;
  localparam int TPA_EN_BATP = 1;
  localparam int TPA_EN_ADAPTER_GOOD = 0;
  localparam logic [15:0] TPA_THR_STEP_MA = 16'h0200;
  localparam logic [15:0] TPA_THR_OFS_MA = 16'h0080;

  // monitor_converter_option fields
  localparam int TPA_ADC_REPEAT = 15;
  localparam int TPA_ADC_START = 14;
  localparam int TPA_ADC_RANGE = 13;
  localparam int TPA_NUM_CHAN = 8;

  // times in microseconds
  localparam int unsigned TPA_DEG_1P6MS_US = 1600;
  localparam int unsigned TPA_DEG_100US_US = 100;
  localparam int unsigned TPA_DEG_6MS_US = 6000;
  localparam int unsigned TPA_DEG_12MS_US = 12000;
  localparam int unsigned TPA_PW_100US_US = 100;
  localparam int unsigned TPA_PW_1MS_US = 1000;
  localparam int unsigned TPA_PW_10MS_US = 10000;
  localparam int unsigned TPA_PW_5MS_US = 5000;
  localparam int unsigned TPA_CONV_SET_US = 10000;
  localparam int unsigned TPA_REPEAT_US = 1000000;

  function automatic int unsigned tpa_us_to_cyc(input int unsigned us);
    return us * TPA_CLK_MHZ;
  endfunction

  typedef enum logic [2:0] {
    TPA_TH_IDLE = 3'b001,
    TPA_TH_HOLD = 3'b010,
    TPA_TH_EXT = 3'b100
  } tpa_th_state_t;

  typedef enum logic [2:0] {
    TPA_AD_IDLE = 3'b001,
    TPA_AD_CONV = 3'b010,
    TPA_AD_WAIT = 3'b100
  } tpa_ad_state_t;
endpackage

//--- rtl/tpa_deglitch.sv
// tpa_deglitch: passes a level once it has stood high for a run-time count.
// assumes raw is already synchronous to core_clk.
`timescale 1ns/100ps
module tpa_deglitch #(
  parameter int CNT_W = 28
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // level in, count, level out
  input wire logic raw,
  input wire logic [CNT_W-1:0] limit,
  output logic clean
);
  logic [CNT_W-1:0] cnt_r;

  // any low sample restarts the qualification; release is immediate
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (!raw) begin
      cnt_r <= '0;
    end else if (cnt_r < limit) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clean <= 1'b0;
    end else begin
      clean <= raw && (cnt_r >= limit);
    end
  end
endmodule

//--- rtl/tpa_top.sv
// tpa_top: throttle profile and monitor converter control registers and logic.
// assumes an i2c slave outside presents byte writes/reads on reg_* in the core
// clock domain, and analog comparators deliver raw levels on asynchronous pins.
`timescale 1ns/100ps
module tpa_top #(
  parameter int unsigned DEG_1P6MS_CYC = tpa_pkg::tpa_us_to_cyc(tpa_pkg::TPA_DEG_1P6MS_US),
  parameter int unsigned DEG_100US_CYC = tpa_pkg::tpa_us_to_cyc(tpa_pkg::TPA_DEG_100US_US),
  parameter int unsigned DEG_6MS_CYC = tpa_pkg::tpa_us_to_cyc(tpa_pkg::TPA_DEG_6MS_US),
  parameter int unsigned DEG_12MS_CYC = tpa_pkg::tpa_us_to_cyc(tpa_pkg::TPA_DEG_12MS_US),
  parameter int unsigned PW_100US_CYC = tpa_pkg::tpa_us_to_cyc(tpa_pkg::TPA_PW_100US_US),
  parameter int unsigned PW_1MS_CYC = tpa_pkg::tpa_us_to_cyc(tpa_pkg::TPA_PW_1MS_US),
  parameter int unsigned PW_10MS_CYC = tpa_pkg::tpa_us_to_cyc(tpa_pkg::TPA_PW_10MS_US),
  parameter int unsigned PW_5MS_CYC = tpa_pkg::tpa_us_to_cyc(tpa_pkg::TPA_PW_5MS_US),
  parameter int unsigned CONV_SET_CYC = tpa_pkg::tpa_us_to_cyc(tpa_pkg::TPA_CONV_SET_US),
  parameter int unsigned REPEAT_CYC = tpa_pkg::tpa_us_to_cyc(tpa_pkg::TPA_REPEAT_US)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // raw trip levels from the analog side (asynchronous)
  input wire logic comparator_trip,
  input wire logic critical_input_current_trip,
  input wire logic nominal_input_current_trip,
  input wire logic system_voltage_low,
  input wire logic battery_present,
  input wire logic adapter_good,
  // same-domain status
  input wire logic [15:0] discharge_current_ma,
  input wire logic charge_option_first_b15,
  input wire logic pulse_extension_enable,
  input wire logic [1:0] pulse_width_select,
  input wire logic pulse_clear_write_zero,
  input wire logic low_power_mode,
  input wire logic battery_only,
  // throttle
  output logic throttle_alert_n,
  // converter control
  output logic converter_range_select,
  output logic low_power_exit_req,
  output logic conv_active,
  output logic [2:0] conv_channel,
  output logic conv_channel_enabled,
  output logic conv_sample,
  output logic results_update
);
  import tpa_pkg::*;

  localparam logic [TPA_CNT_W-1:0] DWELL_CYC = TPA_CNT_W'(CONV_SET_CYC / TPA_NUM_CHAN);

  logic [15:0] prof_r;
  logic [15:0] adc_r;
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic batp_d_r;
  logic adapter_good_d_r;
  logic disch_over;
  logic disch_clean;
  logic [TPA_CNT_W-1:0] deg_limit;
  logic [TPA_CNT_W-1:0] width_limit;
  logic trig_level;
  logic trig_event;
  logic trig_any;
  tpa_th_state_t th_r;
  tpa_th_state_t th_nxt;
  logic [TPA_CNT_W-1:0] th_cnt_r;
  tpa_ad_state_t ad_r;
  logic [TPA_CNT_W-1:0] dwell_r;
  logic [TPA_CNT_W-1:0] per_r;
  logic adc_run;
  logic chan_done;
  logic set_done;

  function automatic logic [15:0] thr_ma(input logic [TPA_THR_W-1:0] code);
    return 16'(code) * TPA_THR_STEP_MA + TPA_THR_OFS_MA;
  endfunction

  // register writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prof_r <= TPA_PROF_RST;
    end else if (reg_wr && reg_addr == TPA_ADDR_PROF_LO) begin
      prof_r[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == TPA_ADDR_PROF_HI) begin
      prof_r[15:8] <= reg_wdata;
    end
  end

  // a host write in the same cycle as the auto-clear wins, so a new start is kept
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      adc_r <= TPA_ADC_RST;
    end else if (reg_wr && reg_addr == TPA_ADDR_ADC_LO) begin
      adc_r[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == TPA_ADDR_ADC_HI) begin
      adc_r[15:8] <= reg_wdata;
    end else if (set_done && !adc_r[TPA_ADC_REPEAT]) begin
      adc_r[TPA_ADC_START] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        TPA_ADDR_PROF_LO: reg_rdata <= prof_r[7:0];
        TPA_ADDR_PROF_HI: reg_rdata <= prof_r[15:8];
        TPA_ADDR_ADC_LO: reg_rdata <= adc_r[7:0];
        TPA_ADDR_ADC_HI: reg_rdata <= adc_r[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // pin synchronisers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {comparator_trip, critical_input_current_trip, nominal_input_current_trip,
                  system_voltage_low, battery_present, adapter_good};
      sync2_r <= sync1_r;
    end
  end

  // presence history starts "present" but the synchronisers reset to 0, so the first cycle after reset looks like a removal
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      batp_d_r <= 1'b1;
      adapter_good_d_r <= 1'b1;
    end else begin
      batp_d_r <= sync2_r[1];
      adapter_good_d_r <= sync2_r[0];
    end
  end

  assign disch_over = discharge_current_ma > thr_ma(prof_r[TPA_THR_LSB +: TPA_THR_W]);

  always_comb begin
    case (prof_r[TPA_DEG_LSB +: 2])
      2'h0: deg_limit = TPA_CNT_W'(DEG_1P6MS_CYC);
      2'h1: deg_limit = TPA_CNT_W'(DEG_100US_CYC);
      2'h2: deg_limit = TPA_CNT_W'(DEG_6MS_CYC);
      default: deg_limit = TPA_CNT_W'(DEG_12MS_CYC);
    endcase
  end

  tpa_deglitch #(.CNT_W(TPA_CNT_W)) u_disch_deg (
    .core_clk(core_clk),
    .rst(rst),
    .raw(disch_over),
    .limit(deg_limit),
    .clean(disch_clean)
  );

  always_comb begin
    case (pulse_width_select)
      2'h0: width_limit = TPA_CNT_W'(PW_100US_CYC);
      2'h1: width_limit = TPA_CNT_W'(PW_1MS_CYC);
      2'h2: width_limit = TPA_CNT_W'(PW_10MS_CYC);
      default: width_limit = TPA_CNT_W'(PW_5MS_CYC);
    endcase
  end

  // other comparators arrive already deglitched by their own analog front end
  assign trig_level = (prof_r[TPA_EN_COMP] && sync2_r[5]) ||
                      (prof_r[TPA_EN_CRIT] && sync2_r[4]) ||
                      (prof_r[TPA_EN_NOM] && sync2_r[3]) ||
                      (prof_r[TPA_EN_DISCH] && disch_clean) ||
                      (prof_r[TPA_EN_SYSV] && sync2_r[2]);
  assign trig_event = (prof_r[TPA_EN_BATP] && batp_d_r && !sync2_r[1]) ||
                      (prof_r[TPA_EN_ADAPTER_GOOD] && adapter_good_d_r && !sync2_r[0] &&
                       !charge_option_first_b15);
  // all enables clear leaves both terms zero, so throttling is off
  assign trig_any = (|prof_r[TPA_PROF_EN_W-1:0]) && (trig_level || trig_event);

  always_comb begin
    th_nxt = th_r;
    case (th_r)
      TPA_TH_IDLE: begin
        if (trig_any) begin
          th_nxt = pulse_extension_enable ? TPA_TH_EXT : TPA_TH_HOLD;
        end
      end
      TPA_TH_HOLD: begin
        if (!trig_any && th_cnt_r >= width_limit - 1'b1) begin
          th_nxt = TPA_TH_IDLE;
        end
      end
      TPA_TH_EXT: begin
        if (pulse_clear_write_zero) begin
          th_nxt = TPA_TH_IDLE;
        end
      end
      default: th_nxt = TPA_TH_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      th_r <= TPA_TH_IDLE;
      th_cnt_r <= '0;
    end else begin
      th_r <= th_nxt;
      // a trigger still present restarts the minimum width
      if (th_r != TPA_TH_HOLD || trig_any) begin
        th_cnt_r <= '0;
      end else if (th_cnt_r < width_limit) begin
        th_cnt_r <= th_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      throttle_alert_n <= 1'b1;
    end else begin
      throttle_alert_n <= (th_nxt == TPA_TH_IDLE);
    end
  end

  // converter sequencer
  assign adc_run = adc_r[TPA_ADC_START] && !low_power_mode;
  assign chan_done = (ad_r == TPA_AD_CONV) && (dwell_r >= DWELL_CYC - 1'b1);
  assign set_done = chan_done && (conv_channel == 3'(TPA_NUM_CHAN - 1));
  assign converter_range_select = adc_r[TPA_ADC_RANGE];
  assign low_power_exit_req = adc_r[TPA_ADC_START] && battery_only;
  assign conv_active = (ad_r == TPA_AD_CONV);
  assign conv_channel_enabled = conv_active && adc_r[conv_channel];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ad_r <= TPA_AD_IDLE;
      dwell_r <= '0;
      per_r <= '0;
      conv_channel <= 3'h0;
    end else if (!adc_run) begin
      ad_r <= TPA_AD_IDLE;
      dwell_r <= '0;
      per_r <= '0;
      conv_channel <= 3'h0;
    end else begin
      per_r <= per_r + 1'b1;
      case (ad_r)
        TPA_AD_IDLE: begin
          ad_r <= TPA_AD_CONV;
          per_r <= '0;
        end
        TPA_AD_CONV: begin
          dwell_r <= chan_done ? '0 : dwell_r + 1'b1;
          if (chan_done) begin
            conv_channel <= conv_channel + 1'b1;
          end
          if (set_done) begin
            ad_r <= adc_r[TPA_ADC_REPEAT] ? TPA_AD_WAIT : TPA_AD_IDLE;
          end
        end
        TPA_AD_WAIT: begin
          if (per_r >= TPA_CNT_W'(REPEAT_CYC) - 1'b1) begin
            ad_r <= TPA_AD_CONV;
            per_r <= '0;
          end
        end
        default: ad_r <= TPA_AD_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv_sample <= 1'b0;
      results_update <= 1'b0;
    end else begin
      conv_sample <= adc_run && chan_done && adc_r[conv_channel];
      results_update <= adc_run && set_done;
    end
  end
endmodule

//--- bench/tpa_monitor.sv
// tpa_monitor: port-level checks on tpa_top.
// assumes throttle widths of at least 8 cycles and one core clock domain.
`timescale 1ns/100ps
module tpa_monitor
  import tpa_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // status levels
  input wire logic low_power_mode,
  input wire logic battery_only,
  input wire logic pulse_extension_enable,
  input wire logic pulse_clear_write_zero,
  // outputs watched
  input wire logic throttle_alert_n,
  input wire logic converter_range_select,
  input wire logic low_power_exit_req,
  input wire logic conv_active,
  input wire logic [2:0] conv_channel,
  input wire logic conv_channel_enabled,
  input wire logic conv_sample,
  input wire logic results_update
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  range_follows_write_a: assert property (reg_wr && reg_addr == TPA_ADDR_ADC_HI |=>
    converter_range_select == $past(reg_wdata[TPA_ADC_RANGE-8])) else $error("range bit wrong");
  low_power_off_a: assert property (low_power_mode |=> !conv_active)
    else $error("converter active in low power");
  exit_request_a: assert property (battery_only && reg_wr && reg_addr == TPA_ADDR_ADC_HI &&
    reg_wdata[TPA_ADC_START-8] |=> low_power_exit_req) else $error("no low power exit");
  channel_order_a: assert property (conv_active && $past(conv_active) && $changed(conv_channel)
    |-> conv_channel == $past(conv_channel) + 3'h1) else $error("channel order broken");
  sample_gate_a: assert property (conv_sample |-> $past(conv_channel_enabled))
    else $error("sample from disabled channel");
  set_end_a: assert property (results_update |-> $past(conv_channel) == 3'h7)
    else $error("update before last channel");
  min_width_a: assert property ($fell(throttle_alert_n) && !pulse_extension_enable
    |-> !throttle_alert_n [*8]) else $error("throttle pulse too short");
  ext_hold_a: assert property (!throttle_alert_n && pulse_extension_enable &&
    !pulse_clear_write_zero |=> !throttle_alert_n) else $error("extended pulse released");
  clear_release_a: assert property (pulse_clear_write_zero && pulse_extension_enable &&
    !throttle_alert_n |=> throttle_alert_n) else $error("clear did not release");
  cover property (results_update);
  cover property ($fell(throttle_alert_n));
  cover property (conv_sample);
  cover property (low_power_exit_req);
endmodule

bind tpa_top tpa_monitor u_mon (.core_clk, .rst, .reg_wr, .reg_addr, .reg_wdata,
  .low_power_mode, .battery_only, .pulse_extension_enable, .pulse_clear_write_zero,
  .throttle_alert_n, .converter_range_select, .low_power_exit_req, .conv_active,
  .conv_channel, .conv_channel_enabled, .conv_sample, .results_update);

//--- bench/tpa_cpu_model.sv
// tpa_cpu_model: processor on the throttle line plus the host's pulse clear write.
// assumes clear_req is raised for one cycle at a rising edge.
`timescale 1ns/100ps
module tpa_cpu_model (
  // clock
  input wire logic core_clk,
  // throttle line and clear request
  input wire logic throttle_alert_n,
  input wire logic clear_req,
  // host write of zero, last low time in cycles
  output logic pulse_clear_write_zero,
  output int low_len
);
  int run = 0;
  initial pulse_clear_write_zero = 1'b0;
  initial low_len = 0;
  always @(posedge core_clk) begin
    if (!throttle_alert_n) run++;
    else if (run != 0) begin
      low_len = run;
      run = 0;
    end
  end
  // one write of zero releases an extended pulse
  always @(negedge core_clk) pulse_clear_write_zero <= clear_req;
endmodule

//--- bench/tpa_top_bench.sv
// tpa_top_bench: register and pin tests of the throttle and converter control.
// assumes shortened counts: deglitch 12/4/14/16, widths 8/16/32/24, set 64, period 200.
`timescale 1ns/100ps
module tpa_top_bench;
  import tpa_pkg::*;
  logic core_clk = 0, rst = 1, reg_wr = 0, comparator_trip = 0, critical_input_current_trip = 0;
  logic nominal_input_current_trip = 0, system_voltage_low = 0, battery_present = 1;
  logic adapter_good = 1, charge_option_first_b15 = 0, pulse_extension_enable = 0;
  logic low_power_mode = 0, battery_only = 0, clear_req = 0, pulse_clear_write_zero;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic [15:0] discharge_current_ma = 16'h0000;
  logic [1:0] pulse_width_select = 2'h0;
  logic throttle_alert_n, converter_range_select, low_power_exit_req, conv_active;
  logic [2:0] conv_channel;
  logic conv_channel_enabled, conv_sample, results_update;
  int fail_count = 0, check_count = 0, cyc = 0, n, k, i, low_len;
  int deg[4] = '{12, 4, 14, 16};
  int pw[4] = '{8, 16, 32, 24};
  logic [7:0] rst_val[4] = '{8'h20, 8'h81, 8'h00, 8'h20};

  tpa_top #(.DEG_1P6MS_CYC(12), .DEG_100US_CYC(4), .DEG_6MS_CYC(14), .DEG_12MS_CYC(16),
    .PW_100US_CYC(8), .PW_1MS_CYC(16), .PW_10MS_CYC(32), .PW_5MS_CYC(24),
    .CONV_SET_CYC(64), .REPEAT_CYC(200)) u_dut (.core_clk, .rst, .reg_wr, .reg_addr,
    .reg_wdata, .reg_rdata, .comparator_trip, .critical_input_current_trip,
    .nominal_input_current_trip, .system_voltage_low, .battery_present, .adapter_good,
    .discharge_current_ma, .charge_option_first_b15, .pulse_extension_enable,
    .pulse_width_select, .pulse_clear_write_zero, .low_power_mode, .battery_only,
    .throttle_alert_n, .converter_range_select, .low_power_exit_req, .conv_active,
    .conv_channel, .conv_channel_enabled, .conv_sample, .results_update);
  tpa_cpu_model u_cpu (.core_clk, .throttle_alert_n, .clear_req, .pulse_clear_write_zero,
    .low_len);

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 12000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  // rdata is registered, so the byte is taken one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    @(negedge core_clk);
    chk("reg_rdata", exp, reg_rdata);
  endtask

  task automatic wait_thr(input logic lvl, input int lim);
    n = 0;
    while (throttle_alert_n !== lvl && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  initial begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    for (i = 0; i < 4; i++) rd(8'h38 + i[7:0], rst_val[i]);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h00);
    wr(8'h38, 8'h08);
    for (i = 0; i < 4; i++) begin
      wr(8'h39, 8'h04 | i[7:0]);
      discharge_current_ma = 16'h0280;
      repeat (30) @(negedge core_clk);
      chk("thr_at_limit", 8'h01, 8'(throttle_alert_n));
      discharge_current_ma = 16'h0281;
      wait_thr(1'b0, 40);
      chk("deglitch", 8'h01, 8'(n >= deg[i] && n <= deg[i] + 4));
      discharge_current_ma = 16'h0000;
      wait_thr(1'b1, 60);
    end
    wr(8'h38, 8'h02);
    for (i = 0; i < 4; i++) begin
      pulse_width_select = i[1:0];
      battery_present = 1'b0;
      wait_thr(1'b0, 10);
      wait_thr(1'b1, 60);
      repeat (5) @(negedge core_clk);
      chk("pulse_len", 8'h01, 8'(low_len >= pw[i] && low_len <= pw[i] + 3));
      chk("one_shot", 8'h01, 8'(throttle_alert_n));
      battery_present = 1'b1;
      repeat (5) @(negedge core_clk);
    end
    wr(8'h38, 8'h01);
    charge_option_first_b15 = 1'b1;
    adapter_good = 1'b0;
    repeat (20) @(negedge core_clk);
    chk("adapter_good_gated", 8'h01, 8'(throttle_alert_n));
    adapter_good = 1'b1;
    charge_option_first_b15 = 1'b0;
    repeat (5) @(negedge core_clk);
    adapter_good = 1'b0;
    wait_thr(1'b0, 10);
    chk("adapter_good_pulse", 8'h00, 8'(throttle_alert_n));
    adapter_good = 1'b1;
    wait_thr(1'b1, 60);
    wr(8'h38, 8'h00);
    comparator_trip = 1'b1;
    discharge_current_ma = 16'hffff;
    battery_present = 1'b0;
    repeat (40) @(negedge core_clk);
    chk("all_off", 8'h01, 8'(throttle_alert_n));
    discharge_current_ma = 16'h0000;
    battery_present = 1'b1;
    comparator_trip = 1'b0;
    pulse_extension_enable = 1'b1;
    wr(8'h38, 8'h40);
    comparator_trip = 1'b1;
    repeat (4) @(negedge core_clk);
    comparator_trip = 1'b0;
    repeat (50) @(negedge core_clk);
    chk("ext_hold", 8'h00, 8'(throttle_alert_n));
    // request moves on the rising edge so the model's falling-edge sample is race free
    @(posedge core_clk);
    clear_req <= 1'b1;
    @(posedge core_clk);
    clear_req <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("ext_clear", 8'h01, 8'(throttle_alert_n));
    pulse_extension_enable = 1'b0;
    wr(8'h38, 8'h34);
    for (i = 0; i < 3; i++) begin
      {critical_input_current_trip, nominal_input_current_trip, system_voltage_low} = 3'b100 >> i;
      wait_thr(1'b0, 10);
      chk("src_level", 8'h00, 8'(throttle_alert_n));
      {critical_input_current_trip, nominal_input_current_trip, system_voltage_low} = 3'h0;
      wait_thr(1'b1, 60);
      chk("src_release", 8'h01, 8'(throttle_alert_n));
    end
    wr(8'h3a, 8'h05);
    wr(8'h3b, 8'h40);
    k = 0;
    wait_thr(1'b1, 1);
    while (results_update !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
      if (conv_sample === 1'b1) k++;
    end
    chk("samples", 8'h02, 8'(k));
    chk("set_time", 8'h01, 8'(n >= 64 && n <= 70));
    chk("range", 8'h00, 8'(converter_range_select));
    rd(8'h3b, 8'h00);
    low_power_mode = 1'b1;
    battery_only = 1'b1;
    wr(8'h3b, 8'h40);
    repeat (3) @(negedge core_clk);
    chk("lp_conv", 8'h00, 8'(conv_active));
    chk("lp_exit", 8'h01, 8'(low_power_exit_req));
    wr(8'h3b, 8'h00);
    low_power_mode = 1'b0;
    battery_only = 1'b0;
    wr(8'h3b, 8'hc0);
    k = 0;
    for (i = 0; i < 450; i++) begin
      @(negedge core_clk);
      if (results_update === 1'b1) k++;
    end
    chk("repeat_sets", 8'h02, 8'(k));
    rd(8'h3b, 8'hc0);
    wr(8'h3b, 8'h00);
    report_and_stop();
  end
endmodule
